// *** rtl/sft_transmitter.sv ***
// sent field transmitter: frame engine, self-test control and apb registers
module sft_transmitter (
   input wire logic pclk, // 50 MHz bus and core clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [11:0] field_in, // converted field word, same clock
   input wire logic sensor_error, // front end error flag, same clock
   output logic conv_start, // one-cycle pulse: start a conversion
   output logic full_scale_sel, // 0: 20.47 mT, 1: 204.7 mT range
   output logic coil_on, // test coil enable
   output logic coil_neg, // test coil polarity negative
   input wire logic sensor_output_pin_i, // wire level of the open-collector output
   output logic sensor_output_pin_o, // driven level, always low
   output logic sensor_output_pin_oe, // high while pulling the wire low
   input wire logic coil_test_pin_n, // self-test pin, active low
   input wire logic sleep_request_pin // sleep request, active high
);
   // input synchronisers: bit0 line, bit1 test pin, bit2 sleep pin
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   wire line_s = sync_q[0];
   wire coil_pin_low_s = ~sync_q[1];
   wire sleep_s = sync_q[2];

   sft_pkg::sft_cfg_t cfg_q;
   logic [15:0] tick_div_q;
   logic [15:0] div_cnt_q;
   logic tick_q;
   sft_pkg::sft_state_t state_q;
   logic [8:0] tcnt_q;
   logic [2:0] nib_idx_q;
   logic [3:0] status_q;
   logic [11:0] field_q;
   logic [7:0] roll_q;
   logic [8:0] low_cnt_q;
   logic [4:0] bist_left_q;
   logic pin_coil_q;
   logic pin_neg_q;
   logic coil_pin_prev_q;
   logic oe_q;
   logic conv_q;
   logic coil_on_q;
   logic coil_neg_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // multiply by x^4 modulo the crc polynomial
   function automatic logic [3:0] crc_shift4(input logic [3:0] c);
      logic [4:0] r;
      r = {1'b0, c};
      for (int i = 0; i < 4; i++) begin
         r = {r[3:0], 1'b0};
         if (r[4]) begin
            r = r ^ sft_pkg::CRC_POLY;
         end
      end
      return r[3:0];
   endfunction

   // nibble order of one message
   function automatic logic [3:0] nib_sel(input logic [2:0] idx, input logic [3:0] st,
                                          input logic [11:0] fld, input logic [7:0] rc);
      logic [3:0] d [6];
      logic [3:0] crc;
      d[0] = fld[11:8];
      d[1] = fld[7:4];
      d[2] = fld[3:0];
      d[3] = rc[7:4];
      d[4] = rc[3:0];
      d[5] = ~fld[11:8];
      crc = sft_pkg::CRC_SEED;
      for (int i = 0; i < 6; i++) begin
         crc = crc_shift4(crc) ^ d[i];
      end
      crc = crc_shift4(crc);
      case (idx)
         3'h0: nib_sel = st;
         3'h7: nib_sel = crc;
         default: nib_sel = d[idx - 3'h1];
      endcase
   endfunction

   // pulse geometry
   wire [3:0] cur_nib = nib_sel(nib_idx_q, status_q, field_q, roll_q);
   wire [8:0] nib_len = sft_pkg::NIB_BASE_TICKS + {5'h00, cur_nib};
   wire [8:0] pulse_len = (state_q == sft_pkg::FS_SYNC) ? sft_pkg::SYNC_TICKS :
                          (state_q == sft_pkg::FS_PAUSE) ? sft_pkg::PAUSE_TICKS :
                          (state_q == sft_pkg::FS_RESUME) ? sft_pkg::RESUME_TICKS : nib_len;
   wire [8:0] low_len = (state_q == sft_pkg::FS_PAUSE) ? sft_pkg::PAUSE_LOW_TICKS
                                                       : sft_pkg::PULSE_LOW_TICKS;
   wire sending = (state_q == sft_pkg::FS_SYNC) || (state_q == sft_pkg::FS_NIB) ||
                  (state_q == sft_pkg::FS_PAUSE);
   wire pulse_end = tick_q && (tcnt_q + 9'h001 == pulse_len);
   wire frame_end = pulse_end && (state_q == sft_pkg::FS_NIB) &&
                    (nib_idx_q == sft_pkg::LAST_NIB);
   wire run_ok = cfg_q.enable && !sleep_s;
   wire hold_seen = sending && !cfg_q.coil_pin_en &&
                    (low_cnt_q == sft_pkg::HOLD_DETECT_TICKS);
   wire drive_low = sending && run_ok && !hold_seen && (tcnt_q < low_len);

   // status of the coming message
   wire bist_act = (bist_left_q != 5'h00);
   wire bist_pos = bist_left_q > sft_pkg::BIST_HALF;
   wire [1:0] st_code = bist_act ? (bist_pos ? sft_pkg::ST_BIST_POS : sft_pkg::ST_BIST_NEG) :
                        (cfg_q.coil_pin_en && pin_coil_q) ?
                           (pin_neg_q ? sft_pkg::ST_BIST_NEG : sft_pkg::ST_BIST_POS) :
                        sensor_error ? sft_pkg::ST_ERROR : sft_pkg::ST_NORMAL;
   wire [3:0] st_nib = {2'b00, st_code};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
      end else begin
         meta_q <= {sleep_request_pin, coil_test_pin_n, sensor_output_pin_i};
         sync_q <= meta_q;
      end
   end

   // tick divider; a change of the period applies at once to the running count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_cnt_q + 16'h0001 >= tick_div_q) begin
         div_cnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // consecutive low ticks on the wire, ours never exceed the pause low phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_q <= 9'h000;
      end else if (line_s || !sending) begin
         low_cnt_q <= 9'h000;
      end else if (tick_q && low_cnt_q != sft_pkg::HOLD_DETECT_TICKS) begin
         low_cnt_q <= low_cnt_q + 9'h001;
      end
   end

   // frame engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= sft_pkg::FS_IDLE;
         tcnt_q <= 9'h000;
         nib_idx_q <= 3'h0;
         status_q <= 4'h0;
         field_q <= 12'h800;
         roll_q <= 8'h00;
         bist_left_q <= 5'h00;
         conv_q <= 1'b0;
      end else begin
         conv_q <= 1'b0;
         if (!run_ok) begin
            state_q <= sft_pkg::FS_IDLE;
            tcnt_q <= 9'h000;
         end else if (hold_seen) begin
            state_q <= sft_pkg::FS_HOLD;
            tcnt_q <= 9'h000;
         end else begin
            case (state_q)
               sft_pkg::FS_IDLE: begin
                  state_q <= sft_pkg::FS_SYNC;
                  tcnt_q <= 9'h000;
                  conv_q <= 1'b1;
               end
               sft_pkg::FS_HOLD: begin
                  if (line_s) begin
                     state_q <= sft_pkg::FS_RESUME;
                     tcnt_q <= 9'h000;
                     bist_left_q <= sft_pkg::BIST_MSGS;
                  end
               end
               default: begin
                  if (pulse_end) begin
                     tcnt_q <= 9'h000;
                     case (state_q)
                        sft_pkg::FS_SYNC: begin
                           state_q <= sft_pkg::FS_NIB;
                           nib_idx_q <= 3'h0;
                           status_q <= st_nib;
                           field_q <= field_in;
                        end
                        sft_pkg::FS_NIB: begin
                           nib_idx_q <= nib_idx_q + 3'h1;
                           if (nib_idx_q == sft_pkg::LAST_NIB) begin
                              roll_q <= roll_q + 8'h01;
                              if (bist_act) begin
                                 bist_left_q <= bist_left_q - 5'h01;
                              end
                              state_q <= cfg_q.pause_en ? sft_pkg::FS_PAUSE
                                                        : sft_pkg::FS_SYNC;
                              conv_q <= !cfg_q.pause_en;
                           end
                        end
                        default: begin
                           state_q <= sft_pkg::FS_SYNC;
                           conv_q <= 1'b1;
                        end
                     endcase
                  end else if (tick_q) begin
                     tcnt_q <= tcnt_q + 9'h001;
                  end
               end
            endcase
         end
      end
   end

   // dedicated test pin: coil on while low, polarity flips per activation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coil_pin_prev_q <= 1'b0;
         pin_coil_q <= 1'b0;
         pin_neg_q <= 1'b1;
      end else begin
         coil_pin_prev_q <= coil_pin_low_s;
         pin_coil_q <= cfg_q.coil_pin_en && coil_pin_low_s;
         if (cfg_q.coil_pin_en && coil_pin_low_s && !coil_pin_prev_q) begin
            pin_neg_q <= ~pin_neg_q;
         end
      end
   end

   // pin and coil outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 1'b0;
         coil_on_q <= 1'b0;
         coil_neg_q <= 1'b0;
      end else begin
         oe_q <= drive_low;
         coil_on_q <= bist_act || pin_coil_q;
         coil_neg_q <= bist_act ? !bist_pos : pin_neg_q;
      end
   end

   // apb slave: one wait-free access phase, answer registered in setup
   wire setup = psel && !penable;
   wire wr_access = psel && penable && pwrite && pready_q;
   wire addr_ok = (paddr == sft_pkg::ADDR_CTRL) || (paddr == sft_pkg::ADDR_TICK) ||
                  (paddr == sft_pkg::ADDR_STATUS) || (paddr == sft_pkg::ADDR_FIELD);
   wire [31:0] rd_mux = (paddr == sft_pkg::ADDR_CTRL) ? {28'h0000_000, cfg_q} :
                        (paddr == sft_pkg::ADDR_TICK) ? {16'h0000, tick_div_q} :
                        (paddr == sft_pkg::ADDR_STATUS) ?
                           {1'b0, bist_left_q, 5'h00, state_q, coil_neg_q,
                            coil_on_q, roll_q, 4'h0, status_q} :
                        (paddr == sft_pkg::ADDR_FIELD) ? {20'h0000_0, field_q} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !addr_ok;
         prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= sft_pkg::CTRL_RST;
         tick_div_q <= sft_pkg::TICK_DIV_RST;
      end else if (wr_access && paddr == sft_pkg::ADDR_CTRL) begin
         cfg_q <= pwdata[3:0];
      end else if (wr_access && paddr == sft_pkg::ADDR_TICK && pwdata[15:0] != 16'h0000) begin
         tick_div_q <= pwdata[15:0];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign conv_start = conv_q;
   assign full_scale_sel = cfg_q.full_scale;
   assign coil_on = coil_on_q;
   assign coil_neg = coil_neg_q;
   assign sensor_output_pin_o = 1'b0;
   assign sensor_output_pin_oe = oe_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SYNC_LEN: assert property (
      (state_q == sft_pkg::FS_SYNC && pulse_end && run_ok && !hold_seen)
      |-> tcnt_q == 9'h037 ##1 state_q == sft_pkg::FS_NIB)
      else $error("calibration pulse length wrong");
   AST_NIB_LEN: assert property (
      (state_q == sft_pkg::FS_NIB && pulse_end) |-> tcnt_q == 9'h00b + {5'h00, cur_nib})
      else $error("nibble length not twelve plus value");
   AST_STATUS_TOP: assert property (
      state_q == sft_pkg::FS_NIB |-> status_q[3:2] == 2'b00)
      else $error("status upper bits not zero");
   AST_INV_NIB: assert property (
      (state_q == sft_pkg::FS_NIB && nib_idx_q == 3'h6) |-> cur_nib == ~field_q[11:8])
      else $error("sixth data nibble not inverted copy");
   AST_ROLL: assert property (
      (frame_end && run_ok && !hold_seen) |=> roll_q == $past(roll_q) + 8'h01)
      else $error("rolling counter did not advance");
   AST_CONV: assert property (
      $rose(state_q == sft_pkg::FS_SYNC) |-> conv_start)
      else $error("conversion not started with calibration pulse");
   AST_SLEEP: assert property (
      sleep_s |=> state_q == sft_pkg::FS_IDLE ##1 !sensor_output_pin_oe)
      else $error("sleep did not stop transmission");
   AST_LOW_PHASE: assert property (
      sensor_output_pin_oe |-> $past(tcnt_q) < sft_pkg::PAUSE_LOW_TICKS)
      else $error("line driven low outside low phase");
   AST_RESUME: assert property (
      (state_q == sft_pkg::FS_RESUME && pulse_end && run_ok)
      |-> tcnt_q == 9'h00b ##1 state_q == sft_pkg::FS_SYNC)
      else $error("resume delay not twelve ticks");
endmodule

// *** rtl/sft_pkg.sv ***
// shared constants, states and config layout for the sent field transmitter
package sft_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_US = 5;
   localparam int TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
   localparam logic [15:0] TICK_DIV_RST = TICK_CYC[15:0];
   localparam logic [8:0] SYNC_TICKS = 9'h038;
   localparam logic [8:0] NIB_BASE_TICKS = 9'h00c;
   localparam logic [8:0] PAUSE_TICKS = 9'h100;
   localparam logic [8:0] PAUSE_LOW_TICKS = 9'h00c;
   localparam logic [8:0] PULSE_LOW_TICKS = 9'h005;
   localparam logic [8:0] RESUME_TICKS = 9'h00c;
   localparam logic [8:0] HOLD_DETECT_TICKS = 9'h09a;
   localparam logic [2:0] LAST_NIB = 3'h7;
   localparam logic [4:0] BIST_MSGS = 5'h10;
   localparam logic [4:0] BIST_HALF = 5'h08;
   // checksum
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [4:0] CRC_POLY = 5'h1d;
   // status nibble codes
   localparam logic [1:0] ST_NORMAL = 2'h0;
   localparam logic [1:0] ST_ERROR = 2'h1;
   localparam logic [1:0] ST_BIST_POS = 2'h2;
   localparam logic [1:0] ST_BIST_NEG = 2'h3;
   // apb map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TICK = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_FIELD = 8'h0c;
   localparam logic [3:0] CTRL_RST = 4'h1;

   typedef enum logic [2:0] {
      FS_IDLE,
      FS_SYNC,
      FS_NIB,
      FS_PAUSE,
      FS_HOLD,
      FS_RESUME
   } sft_state_t;

   typedef struct packed {
      logic coil_pin_en;
      logic full_scale;
      logic pause_en;
      logic enable;
   } sft_cfg_t;
endpackage

// *** test/sft_rx_model.sv ***
// link partner: pull-up wire, self-test hold and falling edge decoder
module sft_rx_model (
   input wire logic pclk, // core clock
   input wire logic line_oe, // device pulls the wire low
   input wire logic hold_req, // bench asks for a self-test hold
   input wire logic [15:0] tick_cyc, // clock cycles per tick
   output logic wire_lvl // resolved wire level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] nib_q [0:7];
   int frames_q = 0;
   int pauses_q = 0;
   int syncs_q = 0;
   int low_q = 0;
   int cnt_q = 0;
   int idx_q = 8;
   int t;
   logic lvl_q = 1'b1;
   // pull-up: high unless a party pulls it down
   assign wire_lvl = !(line_oe || hold_req);
   always @(posedge pclk) begin
      cnt_q++;
      if (lvl_q && !wire_lvl) begin
         t = cnt_q / int'(tick_cyc);
         cnt_q = 0;
         if (t == 56) begin
            syncs_q++;
            idx_q = 0;
         end else if (t == 256) begin
            pauses_q++;
         end else if (idx_q < 8 && t >= 12 && t <= 27) begin
            nib_q[idx_q] = 4'(t - 12);
            idx_q++;
            frames_q += int'(idx_q == 8);
         end else begin
            idx_q = 8;
         end
      end
      if (!lvl_q && wire_lvl) low_q = cnt_q;
      lvl_q = wire_lvl;
   end
endmodule

// *** test/sent_field_transmitter_tb.sv ***
// bench for the sent field transmitter: apb tasks and link scenarios
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %s exp %0h got %0h", n, e, a); end end
module sent_field_transmitter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic pready, pslverr, conv_start, fs_sel, coil_on, coil_neg, pin_o, pin_oe, wire_lvl, e;
   logic [11:0] field_in = 12'h800;
   logic sensor_error = 1'b0;
   logic coil_pin_n = 1'b1;
   logic sleep_pin = 1'b0;
   logic hold_req = 1'b0;
   logic [7:0] rc;
   int num_errors = 0;
   int n_compared = 0;
   int n_conv = 0;
   int k, n, f0;

   sft_transmitter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .field_in(field_in), .sensor_error(sensor_error),
      .conv_start(conv_start), .full_scale_sel(fs_sel), .coil_on(coil_on),
      .coil_neg(coil_neg), .sensor_output_pin_i(wire_lvl), .sensor_output_pin_o(pin_o),
      .sensor_output_pin_oe(pin_oe), .coil_test_pin_n(coil_pin_n),
      .sleep_request_pin(sleep_pin));
   sft_rx_model rx_u (.pclk(pclk), .line_oe(pin_oe), .hold_req(hold_req),
      .tick_cyc(16'h0004), .wire_lvl(wire_lvl));

   initial begin
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) n_conv += int'(conv_start === 1'b1);

   task automatic end_sim;
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         num_errors++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_frames(input int cnt);
      int i;
      f0 = rx_u.frames_q;
      for (i = 0; i < 3000 * cnt && rx_u.frames_q < f0 + cnt; i++) @(negedge pclk);
      if (i >= 3000 * cnt) begin
         num_errors++;
         end_sim();
      end
   endtask

   function automatic logic [3:0] crc4(input logic [3:0] d [6]);
      logic [4:0] c;
      c = 5'h05;
      for (int j = 0; j < 7; j++) begin
         for (int b = 0; b < 4; b++) c = {c[3:0], 1'b0} ^ (c[3] ? 5'h1d : 5'h00);
         if (j < 6) c = c ^ {1'b0, d[j]};
      end
      return c[3:0];
   endfunction

   // first frame after a change may carry stale data: only pick up the counter
   task automatic sync_rc;
      wait_frames(1);
      rc = {rx_u.nib_q[4], rx_u.nib_q[5]} + 8'h01;
   endtask

   task automatic next_frame(input logic [1:0] st, input logic [11:0] f);
      logic [3:0] d [6];
      wait_frames(1);
      d = '{f[11:8], f[7:4], f[3:0], rc[7:4], rc[3:0], ~f[11:8]};
      `CHK("status", {2'b00, st}, rx_u.nib_q[0])
      for (int j = 0; j < 6; j++) `CHK("data", d[j], rx_u.nib_q[j + 1])
      `CHK("crc", crc4(d), rx_u.nib_q[7])
      `CHK("low", 20, rx_u.low_q)
      rc++;
   endtask

   task automatic s_regs;
      apb(1'b0, sft_pkg::ADDR_CTRL, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0001, r)
      apb(1'b0, sft_pkg::ADDR_TICK, 32'h0000_0000);
      `CHK("tick", 32'h0000_00fa, r)
      apb(1'b0, 8'h10, 32'h0000_0000);
      `CHK("unmapped", 1'b1, e)
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0000);
      apb(1'b1, sft_pkg::ADDR_TICK, 32'h0000_0004);
      apb(1'b0, sft_pkg::ADDR_TICK, 32'h0000_0000);
      `CHK("tick wr", 32'h0000_0004, r)
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0001);
   endtask

   task automatic s_normal(input logic [11:0] f);
      @(posedge pclk);
      field_in <= f;
      sync_rc();
      n = n_conv;
      k = rx_u.syncs_q;
      next_frame(2'b00, f);
      next_frame(2'b00, f);
      `CHK("conv", 2, n_conv - n)
      `CHK("syncs", 2, rx_u.syncs_q - k)
      apb(1'b0, sft_pkg::ADDR_FIELD, 32'h0000_0000);
      `CHK("field reg", {20'h0_0000, f}, r)
   endtask

   task automatic s_error_pause;
      @(posedge pclk);
      sensor_error <= 1'b1;
      field_in <= 12'h3c7;
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0007);
      @(negedge pclk);
      `CHK("scale", 1'b1, fs_sel)
      sync_rc();
      k = rx_u.pauses_q;
      next_frame(2'b01, 12'h3c7);
      `CHK("pause", 1, rx_u.pauses_q - k)
      @(posedge pclk);
      sensor_error <= 1'b0;
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0001);
      sync_rc();
   endtask

   task automatic s_bist_wire;
      wait_frames(1);
      @(posedge pclk);
      hold_req <= 1'b1;
      repeat (680) @(posedge pclk);
      hold_req <= 1'b0;
      for (n = 0; n < 200 && pin_oe !== 1'b1; n++) @(negedge pclk);
      `CHK("resume", 1'b1, n >= 48 && n <= 60)
      for (k = 0; k < 17; k++) begin
         // crude coil model: the test coil shifts the converted field
         @(posedge pclk);
         field_in <= (coil_on === 1'b1) ? 12'h8a0 : 12'h800;
         wait_frames(1);
         if (k == 3) `CHK("bist field", 12'h8a0, {rx_u.nib_q[1], rx_u.nib_q[2], rx_u.nib_q[3]})
         `CHK("bist st", k < 8 ? 4'h2 : (k < 16 ? 4'h3 : 4'h0), rx_u.nib_q[0])
         if (k == 3) `CHK("coil", 1'b1, coil_on)
      end
      `CHK("coil off", 1'b0, coil_on)
   endtask

   task automatic s_sleep;
      @(posedge pclk);
      sleep_pin <= 1'b1;
      repeat (20) @(negedge pclk);
      k = 0;
      repeat (2200) @(negedge pclk) k += int'(pin_oe === 1'b1);
      `CHK("sleep", 0, k)
      @(posedge pclk);
      sleep_pin <= 1'b0;
      sync_rc();
   endtask

   task automatic s_coil_pin;
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0009);
      for (k = 0; k < 2; k++) begin
         @(posedge pclk);
         coil_pin_n <= 1'b0;
         repeat (10) @(negedge pclk);
         `CHK("pin coil", 2'b01 | (k << 1), {coil_neg, coil_on})
         @(posedge pclk);
         coil_pin_n <= 1'b1;
         repeat (10) @(negedge pclk);
         `CHK("pin off", 1'b0, coil_on)
      end
      apb(1'b1, sft_pkg::ADDR_CTRL, 32'h0000_0001);
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_normal(12'h9a5);
      s_normal(12'hfff);
      s_normal(12'h000);
      s_error_pause();
      s_bist_wire();
      s_sleep();
      s_coil_pin();
      end_sim();
   end
endmodule
